// ===== rtl/act_regs.sv
// computation threshold register block with avalon-mm slave
// How it works
// - accumulator high byte reads accumulator bits 15:8, sign included
// - accumulator low byte holds accumulator bits 7:0, read and write
// - 16-bit setpoint in two bytes, an operand of the error when selected
// - 16-bit error in two bytes, read only, made by selected calculation
// - error compared with lower and upper thresholds sets two status flags
// - threshold mode decides whether a comparison outcome raises the request
// - data registers have no reset value; reset keeps accumulator and setpoint
module act_regs
	import act_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        calc_done,
	input  wire logic [15:0] result_in,
	input  wire logic [15:0] previous_in,
	input  wire logic [15:0] filter_in,
	input  wire logic        acc_load,
	input  wire logic [15:0] acc_in,
	output logic             upper_threshold_flag,
	output logic             lower_threshold_flag,
	output logic             threshold_req,
	output logic             irq
);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic [15:0] acc_r,  acc_nxt;
	logic [15:0] stpt_r, stpt_nxt;
	logic [15:0] err_r,  err_nxt;
	logic [15:0] lth_r,  lth_nxt;
	logic [15:0] uth_r,  uth_nxt;
	logic [2:0]  calc_sel_r, calc_sel_nxt;
	logic [2:0]  tmd_r,      tmd_nxt;
	logic        uflag_r,    uflag_nxt;
	logic        lflag_r,    lflag_nxt;
	logic        treq_r,     treq_nxt;
	logic [1:0]  istat_r,    istat_nxt;
	logic [1:0]  imask_r,    imask_nxt;
	logic        irq_r,      irq_nxt;
	logic        wait_r,     wait_nxt;
	logic [31:0] rdata_r,    rdata_nxt;

	logic        wr_go;
	logic        rd_take;
	logic        be0;
	logic [7:0]  wbyte;
	logic        above;
	logic        below;
	logic        hit;

	// --------------------------------------------------------------
	// bus handshake
	// --------------------------------------------------------------
	// one wait cycle per access keeps readdata a registered value
	assign rd_take = avs_read && wait_r;
	assign wr_go   = avs_write && !wait_r;
	assign be0     = avs_byteenable[0];
	assign wbyte   = avs_writedata[7:0];

	always_comb begin
		wait_nxt  = 1'b1;
		rdata_nxt = rdata_r;
		if ((avs_read || avs_write) && wait_r) begin
			wait_nxt = 1'b0;
		end
		if (rd_take) begin
			rdata_nxt = RST_RDATA;
			case (avs_address)
				OFS_ACC_HIGH:   rdata_nxt[7:0] = acc_r[15:8];
				OFS_ACC_LOW:    rdata_nxt[7:0] = acc_r[7:0];
				OFS_STPT_HIGH:  rdata_nxt[7:0] = stpt_r[15:8];
				OFS_STPT_LOW:   rdata_nxt[7:0] = stpt_r[7:0];
				OFS_ERR_HIGH:   rdata_nxt[7:0] = err_r[15:8];
				OFS_ERR_LOW:    rdata_nxt[7:0] = err_r[7:0];
				OFS_LTH_HIGH:   rdata_nxt[7:0] = lth_r[15:8];
				OFS_LTH_LOW:    rdata_nxt[7:0] = lth_r[7:0];
				OFS_UTH_HIGH:   rdata_nxt[7:0] = uth_r[15:8];
				OFS_UTH_LOW:    rdata_nxt[7:0] = uth_r[7:0];
				OFS_CTRL_THREE: begin
					rdata_nxt[CALC_SEL_LSB +: 3] = calc_sel_r;
					rdata_nxt[TMD_LSB +: 3]      = tmd_r;
				end
				OFS_STATUS: begin
					rdata_nxt[STAT_LTH_BIT] = lflag_r;
					rdata_nxt[STAT_UTH_BIT] = uflag_r;
				end
				OFS_IRQ_STAT:   rdata_nxt[1:0] = istat_r;
				OFS_IRQ_MASK:   rdata_nxt[1:0] = imask_r;
				default:        rdata_nxt = RST_RDATA;
			endcase
		end
	end

	// --------------------------------------------------------------
	// data registers
	// --------------------------------------------------------------
	always_comb begin
		acc_nxt  = acc_r;
		stpt_nxt = stpt_r;
		err_nxt  = err_r;
		lth_nxt  = lth_r;
		uth_nxt  = uth_r;
		// reset holds the data, it never clears it
		if (rst_n) begin
			if (wr_go && be0) begin
				case (avs_address)
					OFS_ACC_HIGH:  acc_nxt[15:8]  = wbyte;
					OFS_ACC_LOW:   acc_nxt[7:0]   = wbyte;
					OFS_STPT_HIGH: stpt_nxt[15:8] = wbyte;
					OFS_STPT_LOW:  stpt_nxt[7:0]  = wbyte;
					OFS_LTH_HIGH:  lth_nxt[15:8]  = wbyte;
					OFS_LTH_LOW:   lth_nxt[7:0]   = wbyte;
					OFS_UTH_HIGH:  uth_nxt[15:8]  = wbyte;
					OFS_UTH_LOW:   uth_nxt[7:0]   = wbyte;
					default:       acc_nxt        = acc_r;
				endcase
			end
			// converter load wins over a software byte write in the same cycle
			if (acc_load) begin
				acc_nxt = acc_in;
			end
			if (calc_done) begin
				case (calc_sel_r)
					CALC_RES_PREV:  err_nxt = 16'(result_in - previous_in);
					CALC_RES_STPT:  err_nxt = 16'(result_in - stpt_r);
					CALC_FLT_STPT:  err_nxt = 16'(filter_in - stpt_r);
					CALC_PREV_STPT: err_nxt = 16'(previous_in - stpt_r);
					default:        err_nxt = 16'(result_in - stpt_r);
				endcase
			end
		end
	end

	// no reset: contents are unknown at power up and kept over other resets
	always_ff @(posedge clk_sys) begin
		acc_r  <= acc_nxt;
		stpt_r <= stpt_nxt;
		err_r  <= err_nxt;
		lth_r  <= lth_nxt;
		uth_r  <= uth_nxt;
	end

	// --------------------------------------------------------------
	// compare, flags and interrupt
	// --------------------------------------------------------------
	assign above = $signed(err_nxt) > $signed(uth_r);
	assign below = $signed(err_nxt) < $signed(lth_r);

	always_comb begin
		case (tmd_r)
			TMD_NEVER:     hit = 1'b0;
			TMD_BELOW:     hit = below;
			TMD_NOT_BELOW: hit = !below;
			TMD_INSIDE:    hit = !below && !above;
			TMD_OUTSIDE:   hit = below || above;
			TMD_NOT_ABOVE: hit = !above;
			TMD_ABOVE:     hit = above;
			TMD_ALWAYS:    hit = 1'b1;
			default:       hit = 1'b0;
		endcase
	end

	always_comb begin
		calc_sel_nxt = calc_sel_r;
		tmd_nxt      = tmd_r;
		uflag_nxt    = uflag_r;
		lflag_nxt    = lflag_r;
		treq_nxt     = 1'b0;
		imask_nxt    = imask_r;
		istat_nxt    = istat_r;
		if (wr_go && be0 && avs_address == OFS_CTRL_THREE) begin
			calc_sel_nxt = wbyte[CALC_SEL_LSB +: 3];
			tmd_nxt      = wbyte[TMD_LSB +: 3];
		end
		if (wr_go && be0 && avs_address == OFS_IRQ_MASK) begin
			imask_nxt = wbyte[1:0];
		end
		if (wr_go && be0 && avs_address == OFS_IRQ_STAT) begin
			istat_nxt = istat_r & ~wbyte[1:0];
		end
		if (calc_done) begin
			uflag_nxt = above;
			lflag_nxt = below;
			treq_nxt  = hit;
			// a new event beats a write-one-to-clear in the same cycle
			istat_nxt[IRQ_CALC_BIT] = 1'b1;
			if (hit) begin
				istat_nxt[IRQ_THR_BIT] = 1'b1;
			end
		end
		irq_nxt = |(istat_nxt & imask_nxt);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			calc_sel_r <= RST_CALC_SEL;
			tmd_r      <= RST_TMD;
			uflag_r    <= 1'b0;
			lflag_r    <= 1'b0;
			treq_r     <= 1'b0;
			istat_r    <= RST_IRQ;
			imask_r    <= RST_IRQ;
			irq_r      <= 1'b0;
			wait_r     <= 1'b1;
			rdata_r    <= RST_RDATA;
		end else begin
			calc_sel_r <= calc_sel_nxt;
			tmd_r      <= tmd_nxt;
			uflag_r    <= uflag_nxt;
			lflag_r    <= lflag_nxt;
			treq_r     <= treq_nxt;
			istat_r    <= istat_nxt;
			imask_r    <= imask_nxt;
			irq_r      <= irq_nxt;
			wait_r     <= wait_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	assign avs_readdata         = rdata_r;
	assign avs_waitrequest      = wait_r;
	assign upper_threshold_flag = uflag_r;
	assign lower_threshold_flag = lflag_r;
	assign threshold_req        = treq_r;
	assign irq                  = irq_r;

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_acc_high_read: assert property (
		rd_take && avs_address == OFS_ACC_HIGH && !acc_load && !wr_go
		|=> !avs_waitrequest && avs_readdata == {24'h000000, acc_r[15:8]})
		else $error("accumulator high byte read mismatch");

	a_acc_low_write: assert property (
		wr_go && be0 && avs_address == OFS_ACC_LOW && !acc_load
		|=> acc_r[7:0] == $past(avs_writedata[7:0]))
		else $error("accumulator low byte write lost");

	a_stpt_operand: assert property (
		calc_done && calc_sel_r == CALC_RES_STPT
		|=> err_r == 16'($past(result_in) - $past(stpt_r)))
		else $error("setpoint difference wrong");

	a_err_readonly: assert property (
		!calc_done |=> $stable(err_r))
		else $error("error register changed without calculation");

	a_flags_follow: assert property (
		calc_done |=> upper_threshold_flag == ($signed(err_r) > $signed(uth_r))
			&& lower_threshold_flag == ($signed(err_r) < $signed(lth_r)))
		else $error("threshold flags wrong");

	a_mode_never: assert property (
		calc_done && tmd_r == TMD_NEVER |=> !threshold_req)
		else $error("request raised in never mode");

	a_mode_above: assert property (
		calc_done && tmd_r == TMD_ABOVE
		|=> threshold_req == ($signed(err_r) > $signed($past(uth_r))))
		else $error("above mode request wrong");

	a_req_one_cycle: assert property (
		threshold_req |-> $past(calc_done))
		else $error("threshold request without a calculation");

	a_acc_kept: assert property (
		!acc_load && !(wr_go && be0) |=> $stable(acc_r))
		else $error("accumulator changed without a write");

	a_signed_cmp: assert property (
		// thresholds may be rewritten later, so judge against those of the compare itself
		(calc_done ##1 (upper_threshold_flag && lower_threshold_flag))
		|-> $signed($past(uth_r)) < $signed($past(lth_r)))
		else $error("both flags with ordered thresholds");

	a_irq_level: assert property (
		irq == |(istat_r & imask_r))
		else $error("interrupt level wrong");

	a_race_set_wins: assert property (
		calc_done && wr_go && be0 && avs_address == OFS_IRQ_STAT
		|=> istat_r[IRQ_CALC_BIT])
		else $error("interrupt event lost to a clear");

	a_wait_one: assert property (
		(avs_read || avs_write) && wait_r |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("wait cycle length wrong");

	c_thr_irq: cover property (calc_done && hit ##1 irq);
	c_err_read: cover property (rd_take && avs_address == OFS_ERR_HIGH);
	c_clear_race: cover property (calc_done && wr_go && avs_address == OFS_IRQ_STAT);
	c_mode_outside: cover property (calc_done && tmd_r == TMD_OUTSIDE && hit);

endmodule : act_regs

// ===== rtl/act_pkg.sv
// shared constants for the computation threshold register block
package act_pkg;

	// --------------------------------------------------------------
	// register word indices on the avalon bus
	// --------------------------------------------------------------
	localparam logic [3:0] OFS_ACC_HIGH   = 4'h0;
	localparam logic [3:0] OFS_ACC_LOW    = 4'h1;
	localparam logic [3:0] OFS_STPT_HIGH  = 4'h2;
	localparam logic [3:0] OFS_STPT_LOW   = 4'h3;
	localparam logic [3:0] OFS_ERR_HIGH   = 4'h4;
	localparam logic [3:0] OFS_ERR_LOW    = 4'h5;
	localparam logic [3:0] OFS_LTH_HIGH   = 4'h6;
	localparam logic [3:0] OFS_LTH_LOW    = 4'h7;
	localparam logic [3:0] OFS_UTH_HIGH   = 4'h8;
	localparam logic [3:0] OFS_UTH_LOW    = 4'h9;
	localparam logic [3:0] OFS_CTRL_THREE = 4'ha;
	localparam logic [3:0] OFS_STATUS     = 4'hb;
	localparam logic [3:0] OFS_IRQ_STAT   = 4'hc;
	localparam logic [3:0] OFS_IRQ_MASK   = 4'hd;

	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int CALC_SEL_LSB  = 0;   // converter_control_three[2:0]
	localparam int TMD_LSB       = 4;   // converter_control_three[6:4]
	localparam int STAT_LTH_BIT  = 0;   // lower_threshold_flag
	localparam int STAT_UTH_BIT  = 1;   // upper_threshold_flag
	localparam int IRQ_THR_BIT   = 0;   // threshold event
	localparam int IRQ_CALC_BIT  = 1;   // calculation done event

	// --------------------------------------------------------------
	// reset values of control state
	// --------------------------------------------------------------
	localparam logic [2:0]  RST_CALC_SEL = 3'h0;
	localparam logic [2:0]  RST_TMD      = 3'h0;
	localparam logic [1:0]  RST_IRQ      = 2'h0;
	localparam logic [31:0] RST_RDATA    = 32'h0000_0000;

	// --------------------------------------------------------------
	// calculation select codes
	// --------------------------------------------------------------
	localparam logic [2:0] CALC_RES_PREV = 3'h0;
	localparam logic [2:0] CALC_RES_STPT = 3'h1;
	localparam logic [2:0] CALC_FLT_STPT = 3'h2;
	localparam logic [2:0] CALC_PREV_STPT = 3'h3;

	// --------------------------------------------------------------
	// threshold interrupt mode codes
	// --------------------------------------------------------------
	localparam logic [2:0] TMD_NEVER     = 3'h0;
	localparam logic [2:0] TMD_BELOW     = 3'h1;
	localparam logic [2:0] TMD_NOT_BELOW = 3'h2;
	localparam logic [2:0] TMD_INSIDE    = 3'h3;
	localparam logic [2:0] TMD_OUTSIDE   = 3'h4;
	localparam logic [2:0] TMD_NOT_ABOVE = 3'h5;
	localparam logic [2:0] TMD_ABOVE     = 3'h6;
	localparam logic [2:0] TMD_ALWAYS    = 3'h7;

endpackage : act_pkg

// ===== tb/act_regs_tb.sv
// self-checking testbench for the computation threshold register block
module act_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import act_pkg::*;

	// --------------------------------------------------------------
	// signals and instance
	// --------------------------------------------------------------
	localparam logic [15:0] LTH  = 16'hfff0;
	localparam logic [15:0] UTH  = 16'h0064;
	localparam logic [15:0] STPT = 16'h0010;
	logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, calc_done, acc_load;
	logic        upper_threshold_flag, lower_threshold_flag, threshold_req, irq;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata;
	logic [15:0] result_in, previous_in, filter_in, acc_in, v;
	logic [7:0]  rd;
	int          fail_count, checks_done;

	act_regs dut_u (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .calc_done, .result_in, .previous_in, .filter_in, .acc_load,
		.acc_in, .upper_threshold_flag, .lower_threshold_flag, .threshold_req, .irq);

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// --------------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------------
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude

	task check(input string what, input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// request held until waitrequest is sampled low; a hung slave ends the run
	task bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic be);
		int n;
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= {3'h0, be};
		for (n = 0; n < 20; n++) begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'b0) break;
		end
		if (n == 20) begin
			fail_count++;
			conclude();
		end
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 1'b1);
	endtask : wr

	task rdchk(input string what, input logic [3:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00, 1'b1);
		check(what, {8'h0, rd}, {8'h0, exp});
	endtask : rdchk

	task w16(input logic [3:0] a, input logic [15:0] d);
		wr(a, d[15:8]);
		wr(a + 4'h1, d[7:0]);
	endtask : w16

	task get16(input logic [3:0] a);
		bus(1'b0, a, 8'h00, 1'b1);
		v[15:8] = rd;
		bus(1'b0, a + 4'h1, 8'h00, 1'b1);
		v[7:0] = rd;
	endtask : get16

	// calc_done seen at the second edge; threshold_req stands one cycle only, so look just after that edge
	task calc(input logic [15:0] r, input logic [15:0] p, input logic [15:0] f);
		@(posedge clk_sys);
		result_in <= r;
		previous_in <= p;
		filter_in <= f;
		calc_done <= 1'b1;
		@(posedge clk_sys);
		calc_done <= 1'b0;
		#1;
	endtask : calc

	function automatic logic hit(input logic [2:0] m, input logic b, input logic a);
		case (m)
			TMD_NEVER:     hit = 1'b0;
			TMD_BELOW:     hit = b;
			TMD_NOT_BELOW: hit = !b;
			TMD_INSIDE:    hit = !b && !a;
			TMD_OUTSIDE:   hit = b || a;
			TMD_NOT_ABOVE: hit = !a;
			TMD_ABOVE:     hit = a;
			default:       hit = 1'b1;
		endcase
	endfunction : hit

	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task t_idle;
		check("idle wait", {15'h0, avs_waitrequest}, 16'h0001);
		check("irq", {15'h0, irq}, 16'h0000);
		rdchk("control", OFS_CTRL_THREE, 8'h00);
		rdchk("status", OFS_STATUS, 8'h00);
		rdchk("irq mask", OFS_IRQ_MASK, 8'h00);
	endtask : t_idle

	task t_regs;
		w16(OFS_ACC_HIGH, 16'ha55a);
		get16(OFS_ACC_HIGH);
		check("acc", v, 16'ha55a);
		bus(1'b1, OFS_ACC_LOW, 8'hff, 1'b0);
		rdchk("acc low no lane", OFS_ACC_LOW, 8'h5a);
		w16(OFS_STPT_HIGH, STPT);
		get16(OFS_STPT_HIGH);
		check("setpoint", v, STPT);
		w16(OFS_LTH_HIGH, LTH);
		w16(OFS_UTH_HIGH, UTH);
		get16(OFS_LTH_HIGH);
		check("lower thr", v, LTH);
		get16(OFS_UTH_HIGH);
		check("upper thr", v, UTH);
		wr(4'hf, 8'h77);
		rdchk("unmapped", 4'hf, 8'h00);
		@(posedge clk_sys);
		acc_load <= 1'b1;
		acc_in <= 16'h8123;
		@(posedge clk_sys);
		acc_load <= 1'b0;
		get16(OFS_ACC_HIGH);
		check("acc loaded", v, 16'h8123);
	endtask : t_regs

	task t_case(input logic [2:0] sel, input logic [15:0] r, input logic [15:0] p, input logic [15:0] f,
		input logic [15:0] e);
		logic b;
		logic a;
		b = $signed(e) < $signed(LTH);
		a = $signed(e) > $signed(UTH);
		wr(OFS_CTRL_THREE, {5'h0, sel});
		calc(r, p, f);
		check("lower flag", {15'h0, lower_threshold_flag}, {15'h0, b});
		check("upper flag", {15'h0, upper_threshold_flag}, {15'h0, a});
		wr(OFS_ERR_HIGH, ~e[15:8]);
		get16(OFS_ERR_HIGH);
		check("error", v, e);
		rdchk("status", OFS_STATUS, {6'h0, a, b});
	endtask : t_case

	task t_modes;
		logic [15:0] rs [3];
		rs = '{16'hfff0, 16'h0000, 16'h0075};
		for (int m = 0; m < 8; m++) begin
			for (int k = 0; k < 3; k++) begin
				wr(OFS_CTRL_THREE, {1'b0, 3'(m), 1'b0, CALC_RES_STPT});
				calc(rs[k], 16'h0, 16'h0);
				check("thr req", {15'h0, threshold_req}, {15'h0, hit(3'(m), k == 0, k == 2)});
			end
		end
	endtask : t_modes

	task t_irq;
		wr(OFS_IRQ_STAT, 8'h03);
		wr(OFS_CTRL_THREE, {1'b0, TMD_ALWAYS, 1'b0, CALC_RES_STPT});
		calc(16'h0000, 16'h0, 16'h0);
		rdchk("irq stat", OFS_IRQ_STAT, 8'h03);
		check("irq masked", {15'h0, irq}, 16'h0000);
		wr(OFS_IRQ_MASK, 8'h02);
		rdchk("irq mask", OFS_IRQ_MASK, 8'h02);
		check("irq on", {15'h0, irq}, 16'h0001);
		wr(OFS_IRQ_STAT, 8'h02);
		rdchk("irq stat", OFS_IRQ_STAT, 8'h01);
		check("irq off", {15'h0, irq}, 16'h0000);
		wr(OFS_IRQ_MASK, 8'h01);
		rdchk("irq mask", OFS_IRQ_MASK, 8'h01);
		check("irq thr", {15'h0, irq}, 16'h0001);
		// event and write-one-to-clear land on one edge: the event must stay set
		fork
			wr(OFS_IRQ_STAT, 8'h03);
			begin
				@(posedge clk_sys);
				calc(16'h0000, 16'h0, 16'h0);
			end
		join
		rdchk("irq race", OFS_IRQ_STAT, 8'h03);
	endtask : t_irq

	// other reset keeps data registers but clears control state
	task t_rst;
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_idle();
		get16(OFS_ACC_HIGH);
		check("acc kept", v, 16'h8123);
		get16(OFS_STPT_HIGH);
		check("setpoint kept", v, STPT);
	endtask : t_rst

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		{rst_n, avs_read, avs_write, calc_done, acc_load} = '0;
		{avs_address, avs_byteenable, avs_writedata} = '0;
		{result_in, previous_in, filter_in, acc_in} = '0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_idle();
		t_regs();
		t_case(CALC_RES_PREV, 16'h0005, 16'h001e, 16'h0, 16'hffe7);
		t_case(CALC_RES_STPT, 16'h00c8, 16'h0, 16'h0, 16'h00b8);
		t_case(CALC_FLT_STPT, 16'h0, 16'h0, 16'h0032, 16'h0022);
		t_case(CALC_PREV_STPT, 16'h0, 16'h0000, 16'h0, 16'hfff0);
		t_case(3'h7, 16'h0074, 16'h0, 16'h0, 16'h0064);
		t_modes();
		t_irq();
		t_rst();
		conclude();
	end
endmodule : act_regs_tb
